// [hw/xeda_map.vh]
// constants for the expanded data ram access block: register map, fields, timing
// assumes it is included by bare name from the design files of this block
`ifndef XEDA_MAP_VH
`define XEDA_MAP_VH

// ****************************************************************
// register map: word index, byte address is four times the index
// ****************************************************************
`define XEDA_AUX_IDX 10'h08E
`define XEDA_STAT_IDX 10'h08F

// ****************************************************************
// auxiliary control fields and reset value
// ****************************************************************
`define XEDA_AUX_RESET 8'h08
`define XEDA_AUX_WMASK 8'hBF
`define XEDA_AUX_BYPASS 1
`define XEDA_AUX_STRETCH 5

// ****************************************************************
// status fields
// ****************************************************************
`define XEDA_STAT_BUSY 0
`define XEDA_STAT_LAST_EXT 1
`define XEDA_STAT_STRETCH 2

// ****************************************************************
// memory sizes and strobe timing in clock periods
// ****************************************************************
`define XEDA_EXPANDED_DATA_RAM_DEPTH 1792
`define XEDA_EXPANDED_DATA_RAM_AW 11
`define XEDA_EXPANDED_DATA_RAM_TOP 16'h0700
`define XEDA_IRAM_DEPTH 256
`define XEDA_IRAM_AW 8
`define XEDA_STB_W 5
`define XEDA_STB_NORM 5'h06
`define XEDA_STB_LONG 5'h1E

`endif

// [hw/xeda_ram.v]
// flip-flop data ram with combinational read and clocked write
// assumes the caller keeps the address below the depth and gates by clock enable
`timescale 1ns/1ps
`default_nettype none

module xeda_ram #(
  parameter DEPTH = 256,
  parameter AW = 8,
  parameter DW = 8
) (
  input wire i_ref_clk,
  input wire i_ce,
  input wire i_we,
  input wire [AW-1:0] i_addr,
  input wire [DW-1:0] i_wdata,
  output wire [DW-1:0] o_rdata
);

  reg [DW-1:0] mem_q [0:DEPTH-1];

  // contents are not reset: software must write before it reads
  always @(posedge i_ref_clk) begin
    if (i_ce && i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem_q[i_addr];

endmodule // xeda_ram

`default_nettype wire

// [hw/xeda_stb_timer.v]
// down counter that times the low phase of an external strobe
// assumes a load of at least one; o_last marks the final strobe cycle
`timescale 1ns/1ps
`default_nettype none

module xeda_stb_timer #(
  parameter W = 5
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_load,
  input wire [W-1:0] i_len,
  output wire o_last
);

  reg [W-1:0] cnt_q;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (i_ce) begin
      if (i_load) begin
        cnt_q <= i_len;
      end else if (cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign o_last = (cnt_q == {{(W-1){1'b0}}, 1'b1});

endmodule // xeda_stb_timer

`default_nettype wire

// [hw/xeda_top.v]
// steering of external-data moves between expanded data ram and the external bus
// assumes a core on the same clock issuing moves and stack accesses by req/ack,
// and a wishbone classic master on the same clock for the control register
//
// What this block does
// - provide 1792 bytes of expanded data ram
// - bypass clear: moves go to expanded ram
// - expanded ram access leaves bus pins untouched
// - pointer moves above ram size use bus
// - above 0FFH only via 16-bit pointer form
// - bypass set: index move gives 8-bit address
// - bypass set: pointer move gives 16-bit address
// - bypass set: write or read strobe asserted
// - stack reaches only 256-byte internal ram
// - stretch bit lengthens strobes 6 to 30
// - control register holds stretch bit5, bypass bit1
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "xeda_map.vh"

module xeda_top #(
  parameter EXPANDED_DATA_RAM_DEPTH = `XEDA_EXPANDED_DATA_RAM_DEPTH,
  parameter IRAM_DEPTH = `XEDA_IRAM_DEPTH
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_clk_en,
  // wishbone classic slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [11:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire o_wb_ack,
  // core external-data move port
  input wire i_mov_req,
  input wire i_mov_we,
  input wire i_mov_use_pointer,
  input wire [15:0] i_mov_addr,
  input wire [7:0] i_mov_wdata,
  output wire [7:0] o_mov_rdata,
  output wire o_mov_ack,
  // core stack port
  input wire i_stk_req,
  input wire i_stk_we,
  input wire [7:0] i_stk_addr,
  input wire [7:0] i_stk_wdata,
  output wire [7:0] o_stk_rdata,
  output wire o_stk_ack,
  // port two latch value set by software
  input wire [7:0] i_port_two_latch,
  // external multiplexed bus
  input wire [7:0] i_port_zero,
  output wire [7:0] o_port_zero,
  output wire o_port_zero_oe,
  output wire [7:0] o_port_two,
  output wire o_ale,
  output wire o_wr_n,
  output wire o_rd_n
);

  // ****************************************************************
  // local constants
  // ****************************************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_ADDR = 2'b01;
  localparam ST_STRB = 2'b10;
  localparam ST_HOLD = 2'b11;

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else if (i_clk_en) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rst_n = rst_s2_q;

  // port zero read data arrives from outside the clock domain
  reg [7:0] p0_s1_q;
  reg [7:0] p0_s2_q;

  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
    end else if (i_clk_en) begin
      p0_s1_q <= i_port_zero;
      p0_s2_q <= p0_s1_q;
    end
  end

  // ****************************************************************
  // wishbone register file
  // ****************************************************************
  reg [7:0] aux_q;
  reg wb_ack_q;
  reg [31:0] wb_dat_q;
  reg last_ext_q;
  reg [1:0] state_q;
  wire wb_req;
  wire hit_aux;
  wire hit_stat;
  wire bypass;
  wire stretch;
  wire [7:0] stat_val;

  assign wb_req = i_wb_cyc & i_wb_stb & ~wb_ack_q;
  assign hit_aux = (i_wb_adr[11:2] == `XEDA_AUX_IDX);
  assign hit_stat = (i_wb_adr[11:2] == `XEDA_STAT_IDX);
  assign bypass = aux_q[`XEDA_AUX_BYPASS];
  assign stretch = aux_q[`XEDA_AUX_STRETCH];

  assign stat_val = {5'b00000, stretch, last_ext_q, (state_q != ST_IDLE)};

  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_q <= `XEDA_AUX_RESET;
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      wb_ack_q <= wb_req;
      if (wb_req) begin
        wb_dat_q <= 32'h0000_0000;
        if (i_wb_we) begin
          // reserved bit 6 is never stored so it always reads zero
          if (hit_aux && i_wb_sel[0]) begin
            aux_q <= i_wb_dat[7:0] & `XEDA_AUX_WMASK;
          end
        end else if (hit_aux) begin
          wb_dat_q <= {24'h00_0000, aux_q};
        end else if (hit_stat) begin
          wb_dat_q <= {24'h00_0000, stat_val};
        end
      end
    end
  end

  assign o_wb_ack = wb_ack_q;
  assign o_wb_dat = wb_dat_q;

  // ****************************************************************
  // move steering
  // ****************************************************************
  reg mov_ack_q;
  reg [7:0] mov_rdata_q;
  wire mov_take;
  wire mov_int;
  wire [`XEDA_EXPANDED_DATA_RAM_AW-1:0] expanded_data_ram_addr;
  wire [7:0] expanded_data_ram_rdata;

  assign mov_take = i_mov_req & ~mov_ack_q & (state_q == ST_IDLE);

  // index form only ever sees the low 256 locations
  assign mov_int = ~bypass & (~i_mov_use_pointer | (i_mov_addr < `XEDA_EXPANDED_DATA_RAM_TOP));
  assign expanded_data_ram_addr = i_mov_use_pointer ? i_mov_addr[`XEDA_EXPANDED_DATA_RAM_AW-1:0] :
                     {3'b000, i_mov_addr[7:0]};

  xeda_ram #(
    .DEPTH(EXPANDED_DATA_RAM_DEPTH),
    .AW(`XEDA_EXPANDED_DATA_RAM_AW),
    .DW(8)
  ) u_expanded_data_ram (
    .i_ref_clk(i_ref_clk),
    .i_ce(i_clk_en),
    .i_we(mov_take & mov_int & i_mov_we),
    .i_addr(expanded_data_ram_addr),
    .i_wdata(i_mov_wdata),
    .o_rdata(expanded_data_ram_rdata)
  );

  // ****************************************************************
  // stack path into the internal ram only
  // ****************************************************************
  reg stk_ack_q;
  reg [7:0] stk_rdata_q;
  wire stk_take;
  wire [7:0] iram_rdata;

  assign stk_take = i_stk_req & ~stk_ack_q;

  // separate array: no stack address can land in the expanded ram
  xeda_ram #(
    .DEPTH(IRAM_DEPTH),
    .AW(`XEDA_IRAM_AW),
    .DW(8)
  ) u_iram (
    .i_ref_clk(i_ref_clk),
    .i_ce(i_clk_en),
    .i_we(stk_take & i_stk_we),
    .i_addr(i_stk_addr),
    .i_wdata(i_stk_wdata),
    .o_rdata(iram_rdata)
  );

  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stk_ack_q <= 1'b0;
      stk_rdata_q <= 8'h00;
    end else if (i_clk_en) begin
      stk_ack_q <= stk_take;
      if (stk_take && !i_stk_we) begin
        stk_rdata_q <= iram_rdata;
      end
    end
  end

  assign o_stk_ack = stk_ack_q;
  assign o_stk_rdata = stk_rdata_q;

  // ****************************************************************
  // strobe timing
  // ****************************************************************
  wire stb_last;
  wire [`XEDA_STB_W-1:0] stb_len;

  assign stb_len = stretch ? `XEDA_STB_LONG : `XEDA_STB_NORM;

  xeda_stb_timer #(
    .W(`XEDA_STB_W)
  ) u_stb_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_ce(i_clk_en),
    .i_load(state_q == ST_ADDR),
    .i_len(stb_len),
    .o_last(stb_last)
  );

  // ****************************************************************
  // external bus cycle
  // ****************************************************************
  reg ext_we_q;
  reg [7:0] ext_wdata_q;
  reg [7:0] p0_out_q;
  reg p0_oe_q;
  reg [7:0] p2_q;
  reg ale_q;
  reg wr_n_q;
  reg rd_n_q;

  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      mov_ack_q <= 1'b0;
      mov_rdata_q <= 8'h00;
      last_ext_q <= 1'b0;
      ext_we_q <= 1'b0;
      ext_wdata_q <= 8'h00;
      p0_out_q <= 8'h00;
      p0_oe_q <= 1'b0;
      p2_q <= 8'hFF;
      ale_q <= 1'b0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else if (i_clk_en) begin
      mov_ack_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          p2_q <= i_port_two_latch;
          if (mov_take && mov_int) begin
            // answered at once, no bus pin moves
            mov_ack_q <= 1'b1;
            last_ext_q <= 1'b0;
            if (!i_mov_we) begin
              mov_rdata_q <= expanded_data_ram_rdata;
            end
          end else if (mov_take) begin
            state_q <= ST_ADDR;
            last_ext_q <= 1'b1;
            ext_we_q <= i_mov_we;
            ext_wdata_q <= i_mov_wdata;
            p0_out_q <= i_mov_addr[7:0];
            p0_oe_q <= 1'b1;
            ale_q <= 1'b1;
            // index form leaves port two to software paging
            if (i_mov_use_pointer) begin
              p2_q <= i_mov_addr[15:8];
            end
          end
        end
        ST_ADDR: begin
          state_q <= ST_STRB;
          ale_q <= 1'b0;
          wr_n_q <= ~ext_we_q;
          rd_n_q <= ext_we_q;
          p0_out_q <= ext_wdata_q;
          p0_oe_q <= ext_we_q;
        end
        ST_STRB: begin
          if (stb_last) begin
            state_q <= ST_HOLD;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            // synchroniser adds two cycles; the strobe is at least six long
            if (!ext_we_q) begin
              mov_rdata_q <= p0_s2_q;
            end
          end
        end
        ST_HOLD: begin
          state_q <= ST_IDLE;
          p0_oe_q <= 1'b0;
          mov_ack_q <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_mov_ack = mov_ack_q;
  assign o_mov_rdata = mov_rdata_q;
  assign o_port_zero = p0_out_q;
  assign o_port_zero_oe = p0_oe_q;
  assign o_port_two = p2_q;
  assign o_ale = ale_q;
  assign o_wr_n = wr_n_q;
  assign o_rd_n = rd_n_q;

endmodule // xeda_top

`default_nettype wire

// [tb/xeda_ext_mem.sv]
// byte memory on the far side of the multiplexed external bus
// assumes address latched while ale is high and active-low strobes on one clock
`timescale 1ns/1ps
`default_nettype none
// *****
// bus partner
// *****
module xeda_ext_mem (
  input wire logic i_ref_clk,
  input wire logic i_ale,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic [7:0] i_port_zero,
  input wire logic [7:0] i_port_two,
  output logic [7:0] o_port_zero
);
  // plain arrays with a written flag per byte keep free simulators happy
  logic [7:0] mem_q [0:65535];
  logic vld_q [0:65535];
  logic [15:0] adr_q;
  initial begin
    o_port_zero = 8'h00;
    for (int k = 0; k < 65536; k++) vld_q[k] = 1'b0;
  end
  always @(posedge i_ref_clk) begin
    if (i_ale) adr_q <= {i_port_two, i_port_zero};
    if (!i_wr_n) begin
      mem_q[adr_q] <= i_port_zero;
      vld_q[adr_q] <= 1'b1;
    end
    // released bus toggles so a stale byte never passes for data
    if (!i_rd_n && vld_q[adr_q]) o_port_zero <= mem_q[adr_q];
    else o_port_zero <= ~o_port_zero;
  end
endmodule // xeda_ext_mem
`default_nettype wire

// [tb/xeda_top_monitor.sv]
// port-level checker for the expanded data ram steering block
// assumes one clock and a shadow of the control bits taken from bus writes
`timescale 1ns/1ps
`default_nettype none
// *****
// checker
// *****
module xeda_top_monitor #(
  parameter EXPANDED_DATA_RAM_DEPTH = 1792
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_mov_req,
  input wire logic i_mov_use_pointer,
  input wire logic [15:0] i_mov_addr,
  input wire logic [7:0] i_mov_wdata,
  input wire logic o_mov_ack,
  input wire logic i_stk_req,
  input wire logic o_stk_ack,
  input wire logic [7:0] i_port_two_latch,
  input wire logic [7:0] o_port_zero,
  input wire logic o_port_zero_oe,
  input wire logic [7:0] o_port_two,
  input wire logic o_ale,
  input wire logic o_wr_n,
  input wire logic o_rd_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic byp_q, str_q, busy_q, take, xr;
  logic [5:0] low_q;
  assign xr = !byp_q && (!i_mov_use_pointer || i_mov_addr < EXPANDED_DATA_RAM_DEPTH);
  assign take = i_mov_req && !o_mov_ack && !busy_q;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      byp_q <= 1'b0;
      str_q <= 1'b0;
      busy_q <= 1'b0;
      low_q <= 6'h00;
    end else begin
      if (o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr[11:2] == 10'h08e) begin
        byp_q <= i_wb_dat[1];
        str_q <= i_wb_dat[5];
      end
      busy_q <= (take && !xr) || (busy_q && !o_mov_ack);
      low_q <= (!o_wr_n || !o_rd_n) ? low_q + 6'h01 : 6'h00;
    end
  end
  a_wb_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack ##1 !o_wb_ack) else $error("register ack not one cycle");
  a_expanded_data_ram_fast: assert property (take && xr |=> o_mov_ack)
    else $error("internal move not answered next cycle");
  a_expanded_data_ram_quiet: assert property (take && xr
    |=> o_wr_n && o_rd_n && !o_ale && !o_port_zero_oe) else $error("pins moved");
  a_bus_short: assert property (take && !xr && !str_q |-> ##9 o_mov_ack)
    else $error("bus move ack late");
  a_bus_long: assert property (take && !xr && str_q |-> ##33 o_mov_ack)
    else $error("stretched move ack late");
  a_strobe_len: assert property ($rose(o_wr_n && o_rd_n)
    |-> low_q == (str_q ? 6'h1e : 6'h06)) else $error("strobe length wrong");
  a_addr_phase: assert property (o_ale |-> o_port_zero_oe &&
    o_port_zero == i_mov_addr[7:0] &&
    o_port_two == (i_mov_use_pointer ? i_mov_addr[15:8] : i_port_two_latch))
    else $error("address phase wrong");
  a_write_data: assert property (!o_wr_n |-> o_port_zero_oe && o_rd_n &&
    o_port_zero == i_mov_wdata) else $error("write data wrong");
  a_read_float: assert property (!o_rd_n |-> !o_port_zero_oe && o_wr_n)
    else $error("port zero driven in read");
  a_ale_first: assert property ($fell(o_wr_n && o_rd_n) |-> $past(o_ale))
    else $error("strobe without address phase");
  a_stack_local: assert property (i_stk_req && !o_stk_ack
    |=> o_stk_ack && o_wr_n && o_rd_n && !o_ale) else $error("stack left chip");
endmodule // xeda_top_monitor
bind xeda_top xeda_top_monitor #(.EXPANDED_DATA_RAM_DEPTH(EXPANDED_DATA_RAM_DEPTH)) xeda_top_monitor_i (.*);
`default_nettype wire

// [tb/xeda_bench.sv]
// self-checking bench for the expanded data ram steering block
// assumes the bus partner model beside the design and the bound checker
`timescale 1ns/1ps
`default_nettype none
// *****
// bench
// *****
module xeda_bench;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
  logic req = 1'b0, sreq = 1'b0, mwe = 1'b0, ptr = 1'b0;
  logic [11:0] wadr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] madr = 16'h0000;
  logic [7:0] mwd = 8'h00, lat = 8'h00, r;
  logic [31:0] wrd, rv;
  logic [7:0] pin, ext_d, p0, p2, mrd, srd;
  logic wack, mack, sack, oe, ale, wr_n, rd_n;
  int failures = 0, total_checks = 0, ticks = 0;
  assign pin = oe ? p0 : ext_d;
  initial forever #10 clk = ~clk;
  xeda_top xeda_top_i (.i_ref_clk(clk), .i_resetn(rst_n), .i_clk_en(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(wwe), .i_wb_adr(wadr), .i_wb_sel(4'h1),
    .i_wb_dat(wdat), .o_wb_dat(wrd), .o_wb_ack(wack), .i_mov_req(req), .i_mov_we(mwe),
    .i_mov_use_pointer(ptr), .i_mov_addr(madr), .i_mov_wdata(mwd), .o_mov_rdata(mrd),
    .o_mov_ack(mack), .i_stk_req(sreq), .i_stk_we(mwe), .i_stk_addr(madr[7:0]),
    .i_stk_wdata(mwd), .o_stk_rdata(srd), .o_stk_ack(sack), .i_port_two_latch(lat),
    .i_port_zero(pin), .o_port_zero(p0), .o_port_zero_oe(oe), .o_port_two(p2),
    .o_ale(ale), .o_wr_n(wr_n), .o_rd_n(rd_n));
  xeda_ext_mem xeda_ext_mem_i (.i_ref_clk(clk), .i_ale(ale), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_port_zero(pin), .i_port_two(p2), .o_port_zero(ext_d));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      failures++;
      print_verdict;
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // waits have no limit of their own: only the bench timeout ends a hang
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    wadr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (wack !== 1'b1);
    rv = wrd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // s picks the stack port; both ports share the address and data lines
  task automatic mv(input logic s, w, p, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= !s;
    sreq <= s;
    mwe <= w;
    ptr <= p;
    madr <= a;
    mwd <= d;
    do begin
      @(posedge clk);
    end while ((s ? sack : mack) !== 1'b1);
    r = s ? srd : mrd;
    req <= 1'b0;
    sreq <= 1'b0;
  endtask
  task automatic wr_rd(input logic s, p, input logic [15:0] a, input logic [7:0] d,
                       input string nm);
    mv(s, 1'b1, p, a, d);
    mv(s, 1'b0, p, a, 8'h00);
    chk(nm, r, d);
  endtask
  task automatic t_regs;
    wb(1'b0, 12'h238, 32'h0000_0000);
    chk("aux reset", rv[7:0], 8'h08);
    wb(1'b1, 12'h238, 32'h0000_00ff);
    wb(1'b0, 12'h238, 32'h0000_0000);
    chk("aux bits", rv[7:0], 8'hbf);
    wb(1'b0, 12'h3f0, 32'h0000_0000);
    chk("unmapped", rv[7:0], 8'h00);
    wb(1'b1, 12'h238, 32'h0000_0008);
  endtask
  task automatic t_expanded_data_ram;
    wr_rd(1'b0, 1'b1, 16'h06ff, 8'h6f, "expanded_data_ram top");
    wr_rd(1'b0, 1'b0, 16'h0010, 8'h11, "index");
    wr_rd(1'b1, 1'b0, 16'h0010, 8'h22, "stack");
    mv(1'b0, 1'b0, 1'b1, 16'h0010, 8'h00);
    chk("stack apart", r, 8'h11);
    mv(1'b0, 1'b1, 1'b0, 16'h0110, 8'h33);
    mv(1'b0, 1'b0, 1'b1, 16'h0010, 8'h00);
    chk("index low byte", r, 8'h33);
    wr_rd(1'b0, 1'b1, 16'h0700, 8'h3c, "bus boundary");
    wb(1'b0, 12'h23c, 32'h0000_0000);
    chk("status bus", rv[7:0], 8'h02);
  endtask
  // a non-zero paging latch and high address byte tell the two forms apart on port two
  task automatic t_bus;
    lat <= 8'h5a;
    wb(1'b1, 12'h238, 32'h0000_0002);
    wr_rd(1'b0, 1'b0, 16'h3310, 8'ha5, "index bus");
    mv(1'b0, 1'b0, 1'b1, 16'h5a10, 8'h00);
    chk("pointer bus", r, 8'ha5);
    wb(1'b1, 12'h238, 32'h0000_0022);
    wr_rd(1'b0, 1'b1, 16'h1234, 8'h77, "stretched");
    wb(1'b0, 12'h23c, 32'h0000_0000);
    chk("status stretch", rv[7:0], 8'h06);
    wb(1'b1, 12'h238, 32'h0000_0008);
  endtask
  task automatic t_reset;
    wb(1'b1, 12'h238, 32'h0000_0022);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, 12'h238, 32'h0000_0000);
    chk("aux after reset", rv[7:0], 8'h08);
    wb(1'b0, 12'h23c, 32'h0000_0000);
    chk("status after reset", rv[7:0], 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_expanded_data_ram;
    t_bus;
    t_reset;
    print_verdict;
  end
endmodule // xeda_bench
`default_nettype wire
